//--- core/part_pkg.sv
// Package with constants and carriers of the auto-reload pulse timer
package part_pkg;
    localparam int PART_CHANNELS = 4;
    localparam int PART_CAPTURES = 2;
    localparam int PART_PRESCALE_BITS = 7;
    localparam logic [7:0] PART_COUNT_RESET = 8'h00;
    localparam logic [7:0] PART_COUNT_TOP = 8'hFF;
    localparam logic [6:0] PART_PRESCALE_RESET = 7'h00;
    localparam logic [7:0] PART_REG_RESET = 8'h00;
    localparam int PART_SYNC_STAGES = 2;

    typedef struct packed {
        logic clock_source_select;
        logic [2:0] prescaler_tap_select;
        logic counter_run_enable;
        logic overflow_irq_enable;
    } part_control_type;

    typedef struct packed {
        logic [3:0] pulse_output_enable;
        logic [3:0] pulse_output_polarity;
    } part_pulse_control_type;

    typedef struct packed {
        logic [1:0] capture_edge_select;
        logic [1:0] capture_irq_enable;
    } part_capture_control_type;
endpackage

//--- core/part_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module part_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    import part_pkg::*;
    logic [WIDTH-1:0] stage_one;
    logic [WIDTH-1:0] next_stage_one;
    logic [WIDTH-1:0] next_sync_out;

    always_comb begin
        next_stage_one = async_in;
        next_sync_out = stage_one;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stage_one <= '0;
            sync_out <= '0;
        end else begin
            stage_one <= next_stage_one;
            sync_out <= next_sync_out;
        end
    end
endmodule

//--- core/part_capture.sv
// One input-capture channel with edge select and read-locked latch
`timescale 1ns/1ps
module part_capture (
    input wire logic clk,
    input wire logic rst_n_sync,
    input wire logic pin_sync,
    input wire logic capture_edge_select,
    input wire logic [7:0] count,
    input wire logic capture_read,
    output logic [7:0] capture_value_reg,
    output logic capture_flag,
    output logic edge_seen
);
    import part_pkg::*;
    logic pin_last;
    logic next_pin_last;
    logic [7:0] next_capture_value_reg;
    logic next_capture_flag;

    always_comb begin
        next_pin_last = pin_sync;
        // Falling when select is zero, rising when one
        edge_seen = capture_edge_select ? (pin_sync && !pin_last)
                                        : (!pin_sync && pin_last);
        next_capture_value_reg = capture_value_reg;
        next_capture_flag = capture_flag;
        if (capture_read) begin
            next_capture_flag = 1'b0;
        end
        // Locked while flag is set; a new edge on the read cycle wins
        if (edge_seen && (!capture_flag || capture_read)) begin
            next_capture_value_reg = count;
            next_capture_flag = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            pin_last <= 1'b0;
            capture_value_reg <= PART_REG_RESET;
            capture_flag <= 1'b0;
        end else begin
            pin_last <= next_pin_last;
            capture_value_reg <= next_capture_value_reg;
            capture_flag <= next_capture_flag;
        end
    end
endmodule

//--- core/part_timer.sv
// Top of the eight-bit auto-reload pulse timer
`timescale 1ns/1ps
module part_timer #(
    parameter int CHANNELS = part_pkg::PART_CHANNELS
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire part_pkg::part_control_type timer_control_status_reg,
    input wire logic force_reload,
    input wire logic status_read,
    input wire logic [7:0] counter_access_wdata,
    input wire logic counter_access_write,
    input wire logic [7:0] auto_reload_value_reg,
    input wire part_pkg::part_pulse_control_type pulse_output_control_reg,
    input wire logic [CHANNELS*8-1:0] duty_cycle_reg,
    input wire part_pkg::part_capture_control_type capture_control_status_reg,
    input wire logic [1:0] capture_read,
    input wire logic deep_stop,
    input wire logic external_count_clock,
    input wire logic [1:0] capture_input_pin,
    output logic [7:0] counter_access_reg,
    output logic [7:0] status_rdata,
    output logic [7:0] capture_status_rdata,
    output logic [15:0] capture_value_reg,
    output logic overflow_flag,
    output logic overflow_irq,
    output logic capture_irq,
    output logic wake_up,
    output logic [CHANNELS-1:0] pulse_output_pin,
    output logic [CHANNELS-1:0] pulse_output_pin_oe
);
    import part_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Reset release and pin synchronisers
    logic [1:0] rst_pipe;
    logic rst_n_sync;
    logic ext_sync;
    logic [1:0] cap_sync;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_pipe <= 2'b00;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_n_sync = rst_pipe[1];

    part_sync #(.WIDTH(3)) u_sync (
        .clk(clk),
        .rst_b(rst_n_sync),
        .async_in({external_count_clock, capture_input_pin}),
        .sync_out({ext_sync, cap_sync})
    );

    ////////////////////////////////////////////////////////////////////////
    // Prescaler input and counter
    logic ext_last;
    logic next_ext_last;
    logic input_tick;
    logic [6:0] prescale;
    logic [6:0] next_prescale;
    logic [6:0] prescale_inc;
    logic count_tick;
    logic [7:0] count;
    logic [7:0] next_count;
    logic overflow;
    logic reload_now;
    logic next_overflow_flag;
    logic [2:0] tap;

    assign tap = timer_control_status_reg.prescaler_tap_select;

    always_comb begin
        next_ext_last = ext_sync;
        // CPU clock ticks every cycle, external clock on its rising edge
        input_tick = timer_control_status_reg.clock_source_select
                     ? (ext_sync && !ext_last) : 1'b1;
        prescale_inc = prescale + 7'h01;
        // Tap n fires when the low n prescaler bits wrap to zero
        if (tap == 3'h0) begin
            count_tick = input_tick;
        end else begin
            count_tick = input_tick &&
                ((prescale_inc & ((7'h01 << tap) - 7'h01)) == 7'h00);
        end
        count_tick = count_tick && timer_control_status_reg.counter_run_enable;
        reload_now = force_reload &&
                     timer_control_status_reg.counter_run_enable;
        overflow = count_tick && (count == PART_COUNT_TOP);
        next_prescale = prescale;
        next_count = count;
        if (timer_control_status_reg.counter_run_enable && input_tick) begin
            next_prescale = prescale_inc;
        end
        if (count_tick) begin
            if (overflow) begin
                next_count = auto_reload_value_reg;
            end else begin
                next_count = count + 8'h01;
            end
        end
        if (counter_access_write) begin
            next_count = counter_access_wdata;
            next_prescale = PART_PRESCALE_RESET;
        end else if (reload_now) begin
            next_count = auto_reload_value_reg;
            next_prescale = PART_PRESCALE_RESET;
        end
        next_overflow_flag = overflow_flag;
        if (status_read) begin
            next_overflow_flag = 1'b0;
        end
        if (overflow) begin
            next_overflow_flag = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            ext_last <= 1'b0;
            prescale <= PART_PRESCALE_RESET;
            count <= PART_COUNT_RESET;
            overflow_flag <= 1'b0;
        end else begin
            ext_last <= next_ext_last;
            prescale <= next_prescale;
            count <= next_count;
            overflow_flag <= next_overflow_flag;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pulse channels with hidden compare registers
    logic [CHANNELS-1:0] phase;
    logic [CHANNELS-1:0] next_phase;
    logic [7:0] hidden_compare_reg [CHANNELS];
    logic [7:0] next_hidden_compare_reg [CHANNELS];
    logic [CHANNELS-1:0] next_pin;
    logic [CHANNELS-1:0] next_pin_oe;

    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
            always_comb begin
                next_hidden_compare_reg[ch] = hidden_compare_reg[ch];
                next_phase[ch] = phase[ch];
                if (overflow) begin
                    next_hidden_compare_reg[ch] =
                        duty_cycle_reg[ch*8 +: 8];
                    next_phase[ch] = 1'b0;
                end else if (count_tick &&
                             count == hidden_compare_reg[ch]) begin
                    next_phase[ch] = 1'b1;
                end
                // Polarity acts at once; halted output holds its level
                next_pin[ch] = deep_stop ? pulse_output_pin[ch]
                    : (phase[ch] ^ !pulse_output_control_reg
                        .pulse_output_polarity[ch]);
                next_pin_oe[ch] =
                    pulse_output_control_reg.pulse_output_enable[ch];
            end

            always_ff @(posedge clk or negedge rst_n_sync) begin
                if (!rst_n_sync) begin
                    hidden_compare_reg[ch] <= PART_REG_RESET;
                    phase[ch] <= 1'b0;
                    pulse_output_pin[ch] <= 1'b0;
                    pulse_output_pin_oe[ch] <= 1'b0;
                end else begin
                    hidden_compare_reg[ch] <= next_hidden_compare_reg[ch];
                    phase[ch] <= next_phase[ch];
                    pulse_output_pin[ch] <= next_pin[ch] &&
                        next_pin_oe[ch];
                    pulse_output_pin_oe[ch] <= next_pin_oe[ch];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Capture channels
    logic [1:0] cap_flag;
    logic [1:0] cap_edge;

    genvar cc;
    generate
        for (cc = 0; cc < PART_CAPTURES; cc++) begin : g_cap
            part_capture u_cap (
                .clk(clk),
                .rst_n_sync(rst_n_sync),
                .pin_sync(cap_sync[cc]),
                .capture_edge_select(
                    capture_control_status_reg.capture_edge_select[cc]),
                .count(count),
                .capture_read(capture_read[cc]),
                .capture_value_reg(capture_value_reg[cc*8 +: 8]),
                .capture_flag(cap_flag[cc]),
                .edge_seen(cap_edge[cc])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Status and interrupt outputs
    logic [1:0] cie;
    assign cie = capture_control_status_reg.capture_irq_enable;

    always_comb begin
        // Force reload reads as zero
        status_rdata = {timer_control_status_reg.clock_source_select,
                        tap,
                        timer_control_status_reg.counter_run_enable,
                        1'b0,
                        timer_control_status_reg.overflow_irq_enable,
                        overflow_flag};
        capture_status_rdata = {2'b00,
                                capture_control_status_reg
                                    .capture_edge_select,
                                cie, cap_flag};
        counter_access_reg = count;
        overflow_irq = overflow_flag &&
                       timer_control_status_reg.overflow_irq_enable;
        capture_irq = |(cap_flag & cie);
        wake_up = deep_stop && (|(cap_edge & cie));
    end
endmodule

//--- verification/part_timer_sva.sv
// Port-level assertion checker for the auto-reload pulse timer
`timescale 1ns/1ps
module part_timer_sva #(
    parameter int CHANNELS = 4
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire part_pkg::part_control_type timer_control_status_reg,
    input wire logic force_reload,
    input wire logic status_read,
    input wire logic counter_access_write,
    input wire logic [7:0] auto_reload_value_reg,
    input wire part_pkg::part_capture_control_type capture_control_status_reg,
    input wire logic [1:0] capture_read,
    input wire logic [7:0] counter_access_reg,
    input wire logic [7:0] status_rdata,
    input wire logic [7:0] capture_status_rdata,
    input wire logic [15:0] capture_value_reg,
    input wire logic overflow_flag,
    input wire logic overflow_irq,
    input wire logic capture_irq,
    input wire logic [CHANNELS-1:0] pulse_output_pin_oe
);
    import part_pkg::*;
    logic [7:0] cnt;
    logic [1:0] flg;
    assign cnt = counter_access_reg;
    assign flg = capture_status_rdata[1:0];
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////////////
    chk_status_view: assert property (
        status_rdata == {timer_control_status_reg[5:1], 1'b0,
        timer_control_status_reg[0], overflow_flag})
        else $error("status view wrong");
    chk_ovf_irq: assert property (
        overflow_irq == (overflow_flag &&
        timer_control_status_reg.overflow_irq_enable))
        else $error("overflow request wrong");
    chk_cap_irq: assert property (
        capture_irq == |(flg & capture_control_status_reg.capture_irq_enable))
        else $error("capture request wrong");
    chk_ovf_clear: assert property (
        status_read && cnt != 8'hFF |=> !overflow_flag)
        else $error("overflow flag kept after read");
    chk_run_freeze: assert property (
        !timer_control_status_reg.counter_run_enable && !counter_access_write
        |=> $stable(cnt))
        else $error("counter moved while stopped");
    chk_reload_step: assert property (
        $rose(overflow_flag) && !$past(counter_access_write) |->
        cnt == auto_reload_value_reg && $past(cnt) == 8'hFF)
        else $error("overflow without reload from top");
    chk_count_step: assert property (
        cnt != $past(cnt) && $past(cnt) != 8'hFF &&
        !$past(counter_access_write) && !$past(force_reload)
        |-> cnt == $past(cnt) + 8'h01)
        else $error("counter step not one");
    chk_flag_hold: assert property (
        flg[0] && !capture_read[0] |=> flg[0])
        else $error("capture flag lost without read");
    chk_value_lock: assert property (
        flg[1] && !capture_read[1] |=> $stable(capture_value_reg[15:8]))
        else $error("capture value changed while locked");
    cov_overflow: cover property ($rose(overflow_flag));
    cov_capture: cover property (capture_irq);
    cov_pwm_on: cover property (|pulse_output_pin_oe);
endmodule
bind part_timer part_timer_sva #(.CHANNELS(CHANNELS)) u_sva (
    .clk(clk), .rst_b(rst_b),
    .timer_control_status_reg(timer_control_status_reg),
    .force_reload(force_reload), .status_read(status_read),
    .counter_access_write(counter_access_write),
    .auto_reload_value_reg(auto_reload_value_reg),
    .capture_control_status_reg(capture_control_status_reg),
    .capture_read(capture_read), .counter_access_reg(counter_access_reg),
    .status_rdata(status_rdata), .capture_status_rdata(capture_status_rdata),
    .capture_value_reg(capture_value_reg), .overflow_flag(overflow_flag),
    .overflow_irq(overflow_irq), .capture_irq(capture_irq),
    .pulse_output_pin_oe(pulse_output_pin_oe)
);

//--- verification/part_pins_model.sv
// Far-side pin model: event clock source and capture signal drivers
`timescale 1ns/1ps
module part_pins_model #(
    parameter int HALF = 4
) (
    input wire logic clk,
    input wire logic ev_go,
    input wire logic [1:0] cap_lvl,
    output logic external_count_clock,
    output logic [1:0] capture_input_pin
);
    initial begin
        external_count_clock = 1'b0;
        capture_input_pin = 2'b00;
    end
    // Event clock stands low between requested events
    always @(posedge ev_go) begin
        repeat (HALF) @(posedge clk);
        external_count_clock <= 1'b1;
        repeat (HALF) @(posedge clk);
        external_count_clock <= 1'b0;
    end
    always @(posedge clk) begin
        capture_input_pin <= cap_lvl;
    end
endmodule

//--- verification/part_timer_test.sv
// Self-checking bench of the auto-reload pulse timer
`timescale 1ns/1ps
module part_timer_test;
    import part_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, frl = 1'b0, srd = 1'b0, wr = 1'b0;
    logic dstop = 1'b0, ev_go = 1'b0, ext, ovf, ovf_irq, cap_irq, wake, woke;
    part_control_type csr = '0;
    part_pulse_control_type pcr = '0;
    part_capture_control_type icr = '0;
    logic [7:0] wd = 8'h00, arr = 8'h00, cnt, srdata, isr, r, v, c;
    logic [31:0] dcr = 32'h00000000;
    logic [1:0] crd = 2'h0, cap_lvl = 2'h0, cap_pin;
    logic [15:0] icv;
    logic [3:0] pin, oe, pol;
    int error_cnt = 0, total_checks = 0, seed, k, on, off;
    always #2.5 clk = ~clk;
    part_timer uut (
        .clk(clk), .rst_b(rst_b), .timer_control_status_reg(csr),
        .force_reload(frl), .status_read(srd), .counter_access_wdata(wd),
        .counter_access_write(wr), .auto_reload_value_reg(arr),
        .pulse_output_control_reg(pcr), .duty_cycle_reg(dcr),
        .capture_control_status_reg(icr), .capture_read(crd),
        .deep_stop(dstop), .external_count_clock(ext),
        .capture_input_pin(cap_pin), .counter_access_reg(cnt),
        .status_rdata(srdata), .capture_status_rdata(isr),
        .capture_value_reg(icv), .overflow_flag(ovf),
        .overflow_irq(ovf_irq), .capture_irq(cap_irq), .wake_up(wake),
        .pulse_output_pin(pin), .pulse_output_pin_oe(oe)
    );
    part_pins_model #(.HALF(4)) u_pins (
        .clk(clk), .ev_go(ev_go), .cap_lvl(cap_lvl),
        .external_count_clock(ext), .capture_input_pin(cap_pin)
    );
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] exp_on(input logic [7:0] rl,
                                           input logic [7:0] d);
        return 16'(d) - 16'(rl) + 16'h0001;
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        if (error_cnt == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic give_up;
        error_cnt++;
        final_report();
    endtask
    task automatic wait_pin(input int ch, input logic lvl, output int n);
        n = 0;
        while (pin[ch] !== lvl) begin
            step(1);
            n++;
            if (n > 600) give_up();
        end
    endtask
    task automatic wait_change(output int n);
        logic [7:0] old;
        old = cnt;
        n = 0;
        while (cnt === old) begin
            step(1);
            n++;
            if (n > 300) give_up();
        end
    endtask
    task automatic write_count(input logic [7:0] val);
        wd = val;
        wr = 1'b1;
        step(1);
        wr = 1'b0;
        step(1);
    endtask
    initial begin
        #400000;
        give_up();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 17494;
        repeat (2) @(posedge clk);
        #1;
        rst_b = 1'b1;
        step(3);
        chk(cnt, 8'h00);
        chk(srdata, 8'h00);
        for (int n = 0; n < 8; n++) begin
            csr = {1'b0, 3'(n), 2'b00};
            write_count(8'h00);
            csr = {1'b0, 3'(n), 2'b10};
            wait_change(k);
            wait_change(k);
            chk(16'(k), 16'h0001 << n);
        end
        csr = 6'h00;
        c = cnt;
        step(20);
        chk(cnt, c);
        for (int t = 0; t < 3; t++) begin
            r = (t == 0) ? 8'h00 : 8'($random(seed)) & 8'h7F;
            arr = r;
            for (int ch = 0; ch < 4; ch++) begin
                dcr[8*ch +: 8] = r + 8'h01 +
                    8'(($random(seed) & 32'hFFFF) % (254 - r));
            end
            pol = 4'($random(seed));
            pcr = {4'hF, pol};
            csr = {5'b00001, t[0]};
            step(600);
            for (int ch = 0; ch < 4; ch++) begin
                wait_pin(ch, pol[ch], k);
                wait_pin(ch, !pol[ch], k);
                wait_pin(ch, pol[ch], on);
                wait_pin(ch, !pol[ch], off);
                chk(16'(on), exp_on(r, dcr[8*ch +: 8]));
                chk(16'(on + off), 16'h0100 - 16'(r));
            end
            chk(oe, 4'hF);
            chk(ovf, 1'b1);
            chk(ovf_irq, t[0]);
            srd = 1'b1;
            step(1);
            srd = 1'b0;
            chk(ovf, 1'b0);
            dstop = 1'b1;
            c = 8'(pin);
            step(300);
            chk(pin, c[3:0]);
            dstop = 1'b0;
            csr = 6'h00;
            step(1);
        end
        arr = 8'hFD;
        csr = 6'b100010;
        frl = 1'b1;
        step(1);
        frl = 1'b0;
        srd = 1'b1;
        step(1);
        srd = 1'b0;
        chk(cnt, 8'hFD);
        for (int e = 1; e < 4; e++) begin
            ev_go = 1'b1;
            step(1);
            ev_go = 1'b0;
            step(14);
            chk(ovf, e == 3);
        end
        chk(cnt, 8'hFD);
        csr = 6'h00;
        for (int ch = 0; ch < 2; ch++) begin
            for (int es = 0; es < 2; es++) begin
                icr = {2'(es << ch), 2'b11};
                dstop = es[0];
                v = 8'($random(seed));
                write_count(v);
                cap_lvl[ch] = !es[0];
                step(8);
                chk(isr[ch], 1'b0);
                cap_lvl[ch] = es[0];
                k = 0;
                woke = 1'b0;
                while (isr[ch] !== 1'b1 && k < 10) begin
                    woke = woke | wake;
                    step(1);
                    k++;
                end
                woke = woke | wake;
                chk(icv[8*ch +: 8], v);
                chk(cap_irq, 1'b1);
                chk(woke, es[0]);
                icr.capture_irq_enable[ch] = 1'b0;
                step(1);
                chk(cap_irq, 1'b0);
                icr.capture_irq_enable[ch] = 1'b1;
                write_count(~v);
                cap_lvl[ch] = !es[0];
                step(6);
                cap_lvl[ch] = es[0];
                step(8);
                chk(icv[8*ch +: 8], v);
                crd[ch] = 1'b1;
                step(1);
                crd[ch] = 1'b0;
                chk(isr[ch], 1'b0);
            end
        end
        final_report();
    end
endmodule
